// ===== logic/pfrc_cfg.svh
// Timing, register map and field constants for the power-fail restart control block
// Notes on behaviour
// - Power-normal rises about 0.1 s after both logic supplies become available.
// - Power-normal stays only while both logic supplies stay; drops when either is lost.
// - Power-normal low inhibits core memory X and Y drive lines.
// - Power-normal low forces memory-normal low and all core read/write controls inactive.
// - Power-normal low suppresses destructive I/O operations such as drum or disc writes.
// - Every shutdown that cuts off +12 V produces a power transition pulse.
// - Power transition pulse clears both run flip-flops, halting the processor.
// - Power transition pulse sets the fetch-phase flip-flop.
// - Pulse resets interrupt-control flip-flop; I/O cards reset their flag and control.
// - Pulse drives the power-fail flag to the state disabling interrupt priority.
// - Preset switch returns the power-fail flag to the priority-enabled state.
// - Exactly one pulse per turn-on, turn-off, and +12 V failure or shutdown.
// - At turn-on the pulse lasts about 40 ms from logic supplies appearing.
// - During turn-on the pulse ends once +12 V is available.
// - At shutdown the pulse starts when +12 V goes and holds until +4.5 V goes.
// - Low line raises power-fail interrupt, priority 4, vector location 00004.
// - Open thermal switch raises power-fail interrupt and drops the supply-on request.
// - After thermal reclosure normal turn-on runs; processor left halted, not running.
`ifndef PFRC_CFG_SVH
`define PFRC_CFG_SVH

`define PFRC_CLK_MHZ 100
`define PFRC_PON_DELAY_US 100000
`define PFRC_PULSE_MIN_US 40000

`define PFRC_ADR_CTRL 8'h00
`define PFRC_ADR_STATUS 8'h04
`define PFRC_ADR_PULSES 8'h08

`define PFRC_CTRL_SUPPLY_EN 0
`define PFRC_CTRL_PF_CLEAR 1
`define PFRC_CTRL_PRESET 2
`define PFRC_CTRL_RESET 32'h0000_0001

`define PFRC_PF_PRIORITY 3'h4
`define PFRC_PF_VECTOR 15'h0004

`endif

// ===== logic/pfrc_pkg.sv
// Types shared by the power-fail restart control block
package pfrc_pkg;
    typedef enum logic [3:0] {
        PFRC_OFF  = 4'h1,
        PFRC_UP   = 4'h2,
        PFRC_NORM = 4'h4,
        PFRC_DOWN = 4'h8
    } pfrc_seq_e;
    typedef logic [31:0] pfrc_word_t;
endpackage

// ===== logic/pfrc_power_fail_restart.sv
// Power sequencing, power transition pulse and power-fail interrupt with a Wishbone slave
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "pfrc_cfg.svh"
module pfrc_power_fail_restart #(
    parameter int PON_DELAY_CYCLES = `PFRC_PON_DELAY_US * `PFRC_CLK_MHZ,
    parameter int PULSE_MIN_CYCLES = `PFRC_PULSE_MIN_US * `PFRC_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire pfrc_pkg::pfrc_word_t dat_i,
    output pfrc_pkg::pfrc_word_t dat_o,
    output logic ack_o,
    // Supply monitors and panel, all asynchronous
    input wire logic sup_pos45_i,
    input wire logic sup_neg2_i,
    input wire logic sup_pos12_i,
    input wire logic low_line_i,
    input wire logic thermal_closed_i,
    input wire logic preset_sw_i,
    input wire logic mem_norm_sw_i,
    // Processor timing control, same clock
    input wire logic run_start_i,
    input wire logic run_halt_i,
    input wire logic phase_execute_i,
    input wire logic phase_fetch_i,
    input wire logic io_int_on_i,
    input wire logic io_int_off_i,
    input wire logic pf_ack_i,
    input wire logic core_read_req_i,
    input wire logic core_write_req_i,
    // Outputs
    output logic power_normal_qualifier_o,
    output logic memory_normal_qualifier_o,
    output logic xy_drive_enable_o,
    output logic io_destructive_enable_o,
    output logic core_read_o,
    output logic core_write_o,
    output logic power_transition_pulse_o,
    output logic io_card_reset_o,
    output logic run1_o,
    output logic run2_o,
    output logic fetch_phase_o,
    output logic io_int_ctrl_o,
    output logic priority_enable_o,
    output logic pf_irq_o,
    output logic [2:0] pf_irq_priority_o,
    output logic [14:0] pf_irq_vector_o,
    output logic supply_on_request_o
);
    import pfrc_pkg::*;

    localparam int NSYNC = 7;

    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic pos45_s;
    logic neg2_s;
    logic pos12_s;
    logic low_line_s;
    logic thermal_s;
    logic preset_s;
    logic mem_norm_s;
    logic logic_ok;

    pfrc_seq_e seq;
    pfrc_seq_e next_seq;
    logic [31:0] pon_cnt;
    logic [31:0] up_cnt;
    logic power_normal_qualifier;
    logic pulse;

    logic run1;
    logic run2;
    logic fetch;
    logic io_int;
    logic prio_en;
    logic pf_request;
    logic [31:0] ctrl;
    logic [15:0] pulse_count;

    logic wb_req;
    logic wr_ctrl;
    logic sw_clear;
    logic sw_preset;

    // Two flops per pin; only sync_b is read by logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {mem_norm_sw_i, preset_sw_i, thermal_closed_i, low_line_i,
                       sup_pos12_i, sup_neg2_i, sup_pos45_i};
            sync_b <= sync_a;
        end
    end

    assign pos45_s = sync_b[0];
    assign neg2_s = sync_b[1];
    assign pos12_s = sync_b[2];
    assign low_line_s = sync_b[3];
    assign thermal_s = sync_b[4];
    assign preset_s = sync_b[5];
    assign mem_norm_s = sync_b[6];
    assign logic_ok = pos45_s & neg2_s;

    // Delay stands in for the charging capacitor; restarts on any loss of either supply
    always_ff @(posedge clk_i) begin
        if (rst_i || !logic_ok) begin
            pon_cnt <= '0;
        end else if (pon_cnt < 32'(PON_DELAY_CYCLES)) begin
            pon_cnt <= pon_cnt + 32'h1;
        end
    end

    assign power_normal_qualifier = logic_ok && (pon_cnt == 32'(PON_DELAY_CYCLES));

    always_comb begin
        next_seq = seq;
        case (seq)
            PFRC_OFF: begin
                if (logic_ok) begin
                    next_seq = PFRC_UP;
                end
            end
            PFRC_UP: begin
                if (!logic_ok) begin
                    next_seq = PFRC_OFF;
                end else if (pos12_s && up_cnt >= 32'(PULSE_MIN_CYCLES)) begin
                    next_seq = PFRC_NORM;
                end
            end
            PFRC_NORM: begin
                if (!logic_ok) begin
                    next_seq = PFRC_OFF;
                end else if (!pos12_s) begin
                    next_seq = PFRC_DOWN;
                end
            end
            PFRC_DOWN: begin
                // +12 V coming back keeps one unbroken pulse and reruns the turn-on hold
                if (!logic_ok) begin
                    next_seq = PFRC_OFF;
                end else if (pos12_s) begin
                    next_seq = PFRC_UP;
                end
            end
            default: begin
                next_seq = PFRC_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq <= PFRC_OFF;
        end else begin
            seq <= next_seq;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || seq != PFRC_UP) begin
            up_cnt <= '0;
        end else if (up_cnt < 32'(PULSE_MIN_CYCLES)) begin
            up_cnt <= up_cnt + 32'h1;
        end
    end

    assign pulse = (seq == PFRC_UP) || (seq == PFRC_DOWN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_count <= '0;
        end else if (seq == PFRC_OFF && next_seq == PFRC_UP) begin
            pulse_count <= pulse_count + 16'h1;
        end else if (seq == PFRC_NORM && next_seq == PFRC_DOWN) begin
            pulse_count <= pulse_count + 16'h1;
        end
    end

    // Pulse and dead logic supplies win over every clocked update
    always_ff @(posedge clk_i) begin
        if (rst_i || pulse || !logic_ok) begin
            run1 <= 1'b0;
            run2 <= 1'b0;
        end else if (run_halt_i) begin
            run1 <= 1'b0;
            run2 <= 1'b0;
        end else if (run_start_i && prio_en) begin
            run1 <= 1'b1;
            run2 <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pulse || !logic_ok) begin
            fetch <= 1'b1;
        end else if (phase_execute_i) begin
            fetch <= 1'b0;
        end else if (phase_fetch_i) begin
            fetch <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pulse || !logic_ok) begin
            io_int <= 1'b0;
        end else if (io_int_off_i) begin
            io_int <= 1'b0;
        end else if (io_int_on_i) begin
            io_int <= 1'b1;
        end
    end

    // Priority stays disabled after power-up until a preset from the panel switch or the control register
    always_ff @(posedge clk_i) begin
        if (rst_i || pulse || !logic_ok) begin
            prio_en <= 1'b0;
        end else if (preset_s || sw_preset) begin
            prio_en <= 1'b1;
        end
    end

    // Events hold the request; a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pf_request <= 1'b0;
        end else if (logic_ok && (low_line_s || !thermal_s)) begin
            pf_request <= 1'b1;
        end else if (pf_ack_i || sw_clear || pulse) begin
            pf_request <= 1'b0;
        end
    end

    assign wb_req = cyc_i && stb_i && !ack_o;
    assign wr_ctrl = wb_req && we_i && sel_i[0] && (adr_i == `PFRC_ADR_CTRL);
    assign sw_clear = wr_ctrl && dat_i[`PFRC_CTRL_PF_CLEAR];
    assign sw_preset = wr_ctrl && dat_i[`PFRC_CTRL_PRESET];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_req;
        end
    end

    // Only the supply enable is stored; clear and preset act as strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `PFRC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl[`PFRC_CTRL_SUPPLY_EN] <= dat_i[`PFRC_CTRL_SUPPLY_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (wb_req && !we_i) begin
            if (adr_i == `PFRC_ADR_CTRL) begin
                dat_o <= {31'h0, ctrl[`PFRC_CTRL_SUPPLY_EN]};
            end else if (adr_i == `PFRC_ADR_STATUS) begin
                dat_o <= {16'h0, seq, low_line_s, thermal_s, pos12_s, neg2_s, pos45_s,
                          pf_request, prio_en, io_int, fetch, run1 | run2, pulse, power_normal_qualifier};
            end else if (adr_i == `PFRC_ADR_PULSES) begin
                dat_o <= {16'h0, pulse_count};
            end else begin
                dat_o <= '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_normal_qualifier_o <= 1'b0;
            memory_normal_qualifier_o <= 1'b0;
            xy_drive_enable_o <= 1'b0;
            io_destructive_enable_o <= 1'b0;
            power_transition_pulse_o <= 1'b0;
            supply_on_request_o <= 1'b0;
            pf_irq_o <= 1'b0;
        end else begin
            power_normal_qualifier_o <= power_normal_qualifier;
            memory_normal_qualifier_o <= power_normal_qualifier && mem_norm_s;
            xy_drive_enable_o <= power_normal_qualifier;
            io_destructive_enable_o <= power_normal_qualifier;
            power_transition_pulse_o <= pulse;
            supply_on_request_o <= thermal_s && ctrl[`PFRC_CTRL_SUPPLY_EN];
            pf_irq_o <= pf_request && prio_en;
        end
    end

    // Core controls gate combinationally so no request leaks past a falling qualifier
    assign core_read_o = core_read_req_i && memory_normal_qualifier_o && power_normal_qualifier;
    assign core_write_o = core_write_req_i && memory_normal_qualifier_o && power_normal_qualifier;
    assign io_card_reset_o = power_transition_pulse_o;
    assign run1_o = run1 && !pulse;
    assign run2_o = run2 && !pulse;
    assign fetch_phase_o = fetch || pulse;
    assign io_int_ctrl_o = io_int && !pulse;
    assign priority_enable_o = prio_en && !pulse;
    assign pf_irq_priority_o = `PFRC_PF_PRIORITY;
    assign pf_irq_vector_o = `PFRC_PF_VECTOR;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    pon_delay_a: assert property ($rose(power_normal_qualifier) |-> $past(pon_cnt) == 32'(PON_DELAY_CYCLES - 1))
        else $error("power-normal rose before the full delay");
    pon_drop_a: assert property (!logic_ok |=> !power_normal_qualifier_o)
        else $error("power-normal held with a logic supply lost");
    xy_gate_a: assert property (!power_normal_qualifier |=> !xy_drive_enable_o)
        else $error("core drive enabled without power-normal");
    core_gate_a: assert property (!power_normal_qualifier_o |->
        !core_read_o && !core_write_o && !memory_normal_qualifier_o)
        else $error("core control active without power-normal");
    io_gate_a: assert property (!power_normal_qualifier |=> !io_destructive_enable_o)
        else $error("destructive I/O enabled without power-normal");
    shutdown_pulse_a: assert property (seq == PFRC_NORM && logic_ok && !pos12_s |=>
        pulse ##1 power_transition_pulse_o)
        else $error("no pulse when +12 V was lost");
    run_clear_a: assert property (pulse |=>
        !run1 && !run2 && fetch && !io_int && !prio_en)
        else $error("pulse did not force halted fetch state");
    override_a: assert property (pulse |-> !run1_o && fetch_phase_o && !priority_enable_o)
        else $error("clocked state escaped the pulse override");
    preset_a: assert property (preset_s && !pulse && logic_ok |=> prio_en)
        else $error("preset did not enable priority");
    turnon_hold_a: assert property ($fell(pulse) && seq == PFRC_NORM |->
        $past(up_cnt) >= 32'(PULSE_MIN_CYCLES) && $past(pos12_s))
        else $error("turn-on pulse ended early");
    pulse_hold_a: assert property (seq == PFRC_DOWN && logic_ok |=> pulse)
        else $error("shutdown pulse ended with +4.5 V present");
    pf_irq_a: assert property (logic_ok && low_line_s |=> pf_request)
        else $error("low line did not raise power-fail request");
    thermal_a: assert property (!thermal_s |=> !supply_on_request_o)
        else $error("supply-on request held with thermal switch open");

    // Pulse staging; a one-cycle supply dropout must end the pulse, not stretch it
    pulse_out_a: assert property (pulse |=> power_transition_pulse_o && io_card_reset_o)
        else $error("pulse not carried to the outputs");
    ptp_fall_a: assert property (!pulse |=> !power_transition_pulse_o)
        else $error("pulse output outlived the internal pulse");
    turnon_start_a: assert property (seq == PFRC_OFF && logic_ok |=> pulse)
        else $error("no pulse when logic supplies appeared");
    up_hold_a: assert property (seq == PFRC_UP && logic_ok && !pos12_s |=> pulse)
        else $error("turn-on pulse ended before +12 V");
    supply_lost_a: assert property (!logic_ok |=> !pulse)
        else $error("pulse held after a logic supply was lost");
    halted_after_a: assert property ($fell(pulse) |-> !run1 && !run2)
        else $error("processor running as the pulse ended");
    fetch_hold_a: assert property (!logic_ok |=> fetch && !run1 && !run2)
        else $error("run state kept with a logic supply lost");

    // Qualifier and interrupt gating
    pon_out_a: assert property (power_normal_qualifier |=> power_normal_qualifier_o)
        else $error("power-normal output lagged the qualifier");
    xy_on_a: assert property (power_normal_qualifier |=> xy_drive_enable_o && io_destructive_enable_o)
        else $error("core drive or I/O writes held off with power-normal");
    mns_switch_a: assert property (!mem_norm_s |=> !memory_normal_qualifier_o)
        else $error("memory-normal set with the panel switch off");
    pf_mask_a: assert property (!prio_en |=> !pf_irq_o)
        else $error("power-fail interrupt passed a disabled priority system");
    thermal_pf_a: assert property (logic_ok && !thermal_s |=> pf_request)
        else $error("open thermal switch did not raise power-fail request");
endmodule

// ===== sim/pfrc_supply_model.sv
// Supply monitors and one I/O card standing at the far side of the power-fail block
`timescale 1ns/100ps
module pfrc_supply_model (
    input wire logic clk_i,
    input wire logic power_sw_i,
    input wire logic fail12_i,
    input wire logic [7:0] p12_dly_i,
    input wire logic supply_on_request_i,
    input wire logic io_card_reset_i,
    input wire logic card_set_i,
    input wire logic io_destructive_enable_i,
    output logic sup_pos45_o,
    output logic sup_neg2_o,
    output logic sup_pos12_o,
    output logic card_flag_o,
    output logic disc_wr_o
);
    logic [7:0] cnt;
    logic [3:0] offc;
    wire logic on = power_sw_i & supply_on_request_i;
    initial begin
        sup_pos45_o = 1'h0;
        sup_neg2_o = 1'h0;
        sup_pos12_o = 1'h0;
        card_flag_o = 1'h0;
        cnt = 8'h00;
        offc = 4'h8;
    end
    always @(posedge clk_i) begin
        if (on === 1'h1) begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            offc <= 4'h0;
            sup_pos45_o <= 1'h1;
            sup_neg2_o <= 1'h1;
            sup_pos12_o <= (cnt >= p12_dly_i) && !fail12_i;
        end else begin
            // The +12 rail goes first; logic rails hold on filter charge a while
            cnt <= 8'h00;
            sup_pos12_o <= 1'h0;
            if (offc == 4'h8) begin
                sup_pos45_o <= 1'h0;
                sup_neg2_o <= 1'h0;
            end else begin
                offc <= offc + 4'h1;
            end
        end
    end
    always @(posedge clk_i) begin
        if (io_card_reset_i === 1'h1) card_flag_o <= 1'h0;
        else if (card_set_i) card_flag_o <= 1'h1;
    end
    assign disc_wr_o = card_set_i & io_destructive_enable_i;
endmodule

// ===== sim/power_fail_restart_control_tb_top.sv
// Self-checking bench for the power-fail restart block
`timescale 1ns/100ps
module power_fail_restart_control_tb_top;
    import pfrc_pkg::*;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic low_line_i = 1'h0, thermal_closed_i = 1'h1, preset_sw_i = 1'h0, mem_norm_sw_i = 1'h1;
    logic run_start_i = 1'h0, run_halt_i = 1'h0, phase_execute_i = 1'h0, phase_fetch_i = 1'h0;
    logic io_int_on_i = 1'h0, io_int_off_i = 1'h0, pf_ack_i = 1'h0;
    logic core_read_req_i = 1'h0, core_write_req_i = 1'h0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    pfrc_word_t dat_i = 32'h0, dat_o, qm[$], qv[$];
    string qn[$];
    wire logic sup_pos45_i, sup_neg2_i, sup_pos12_i;
    logic ack_o, power_normal_qualifier_o, memory_normal_qualifier_o, xy_drive_enable_o;
    logic io_destructive_enable_o, core_read_o, core_write_o, power_transition_pulse_o;
    logic io_card_reset_o, run1_o, run2_o, fetch_phase_o, io_int_ctrl_o, priority_enable_o;
    logic pf_irq_o, supply_on_request_o, card_flag, disc_wr, pp = 1'h0;
    logic power_sw = 1'h0, fail12 = 1'h0, card_set = 1'h0;
    logic [2:0] pf_irq_priority_o;
    logic [14:0] pf_irq_vector_o;
    logic [7:0] p12_dly = 8'h03;
    int n_fail = 0, checks = 0, cyc_n = 0, pulses = 0, t0;
    wire logic ptp = power_transition_pulse_o;
    wire logic pnq = power_normal_qualifier_o;
    pfrc_power_fail_restart #(.PON_DELAY_CYCLES(50), .PULSE_MIN_CYCLES(20)) dut_u (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .sup_pos45_i, .sup_neg2_i, .sup_pos12_i, .low_line_i, .thermal_closed_i,
        .preset_sw_i, .mem_norm_sw_i, .run_start_i, .run_halt_i, .phase_execute_i,
        .phase_fetch_i, .io_int_on_i, .io_int_off_i, .pf_ack_i, .core_read_req_i,
        .core_write_req_i, .power_normal_qualifier_o, .memory_normal_qualifier_o,
        .xy_drive_enable_o, .io_destructive_enable_o, .core_read_o, .core_write_o,
        .power_transition_pulse_o, .io_card_reset_o, .run1_o, .run2_o, .fetch_phase_o,
        .io_int_ctrl_o, .priority_enable_o, .pf_irq_o, .pf_irq_priority_o,
        .pf_irq_vector_o, .supply_on_request_o);
    pfrc_supply_model model_u (.clk_i, .power_sw_i(power_sw), .fail12_i(fail12),
        .p12_dly_i(p12_dly), .supply_on_request_i(supply_on_request_o),
        .io_card_reset_i(io_card_reset_o), .card_set_i(card_set),
        .io_destructive_enable_i(io_destructive_enable_o), .sup_pos45_o(sup_pos45_i),
        .sup_neg2_o(sup_neg2_i), .sup_pos12_o(sup_pos12_i), .card_flag_o(card_flag),
        .disc_wr_o(disc_wr));
    initial forever #5 clk_i = ~clk_i;
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return ptp;
            1: return pnq;
            2: return pf_irq_o;
            3: return sup_pos12_i;
            default: return supply_on_request_o;
        endcase
    endfunction
    // Every wait is bounded so a stuck sequencer ends the run instead of hanging it
    task automatic wfor(input int s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && sig(s) !== v; k++) @(posedge clk_i);
        if (k == lim) begin
            n_fail++;
            $display("[ERR] wait %0d expected %b seen timeout", s, v);
            conclude();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input pfrc_word_t d,
                      input pfrc_word_t m, input string nm);
        int k;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        if (!w) begin
            qm.push_back(m);
            qv.push_back(d & m);
            qn.push_back(nm);
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'h1 && k < 20);
        chk(ack_o, 1'h1, "bus ack");
        if (ack_o !== 1'h1) conclude();
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        pp <= ptp;
        if (ptp === 1'h1 && pp === 1'h0) pulses <= pulses + 1;
        if (cyc_n == 20000) wfor(0, ~ptp, 0);
        if (ack_o === 1'h1 && we_i === 1'h0) begin
            if (qm.size() == 0) chk(1'h1, 1'h0, "stray read ack");
            else chk(dat_o & qm.pop_front(), qv.pop_front(), qn.pop_front());
        end
    end
    initial begin
        void'($urandom(20580));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb(1'h0, 8'h00, 32'h1, 32'h1, "ctrl reset value");
        wb(1'h0, 8'h0c, 32'h0, 32'hffffffff, "unmapped read");
        core_read_req_i <= 1'h1;
        power_sw <= 1'h1;
        wfor(0, 1'h1, 20);
        t0 = cyc_n;
        chk(fetch_phase_o, 1'h1, "fetch at turn-on");
        chk(core_read_o | xy_drive_enable_o | memory_normal_qualifier_o, 0, "core idle");
        chk(io_destructive_enable_o, 1'h0, "io writes blocked");
        repeat (15) @(posedge clk_i);
        chk(ptp, 1'h1, "turn-on pulse held");
        while (cyc_n - t0 < 40) @(posedge clk_i);
        chk(ptp | pnq, 1'h0, "qualifier early");
        wfor(1, 1'h1, 30);
        chk(cyc_n - t0 inside {[45:56]}, 1'h1, "qualifier delay");
        chk(pulses, 1, "turn-on pulse count");
        $display("test turn_on done");
        preset_sw_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        preset_sw_i <= 1'h0;
        run_start_i <= 1'h1;
        phase_execute_i <= 1'h1;
        io_int_on_i <= 1'h1;
        card_set <= 1'h1;
        core_write_req_i <= 1'($urandom() % 2);
        @(posedge clk_i);
        run_start_i <= 1'h0;
        phase_execute_i <= 1'h0;
        io_int_on_i <= 1'h0;
        card_set <= 1'h0;
        chk(core_write_o, core_write_req_i, "core write gate");
        repeat (2) @(posedge clk_i);
        chk({priority_enable_o, run1_o, fetch_phase_o}, 3'h6, "preset and run");
        chk({run2_o, io_int_ctrl_o, card_flag}, 3'h7, "run state set");
        chk(core_read_o & xy_drive_enable_o & io_destructive_enable_o, 1'h1, "core live");
        mem_norm_sw_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        chk({pnq, memory_normal_qualifier_o, core_read_o}, 3'h4, "memory switch off");
        mem_norm_sw_i <= 1'h1;
        low_line_i <= 1'h1;
        wfor(2, 1'h1, 10);
        chk({pf_irq_priority_o, pf_irq_vector_o}, {3'h4, 15'h0004}, "pf vector");
        low_line_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        pf_ack_i <= 1'h1;
        @(posedge clk_i);
        pf_ack_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk(pf_irq_o, 1'h0, "pf acknowledged");
        run_halt_i <= 1'h1;
        phase_fetch_i <= 1'h1;
        io_int_off_i <= 1'h1;
        @(posedge clk_i);
        run_halt_i <= 1'h0;
        phase_fetch_i <= 1'h0;
        io_int_off_i <= 1'h0;
        run_start_i <= 1'h1;
        phase_execute_i <= 1'h1;
        io_int_on_i <= 1'h1;
        @(posedge clk_i);
        chk({run1_o, run2_o, fetch_phase_o, io_int_ctrl_o}, 4'h2, "halt strobes");
        run_start_i <= 1'h0;
        phase_execute_i <= 1'h0;
        io_int_on_i <= 1'h0;
        @(posedge clk_i);
        $display("test run_and_irq done");
        fail12 <= 1'h1;
        wfor(0, 1'h1, 10);
        @(posedge clk_i);
        chk(pnq, 1'h1, "qualifier kept on +12 loss");
        chk({run1_o, run2_o, fetch_phase_o}, 3'h1, "halted in fetch");
        chk({io_int_ctrl_o, priority_enable_o, card_flag}, 3'h0, "io and priority off");
        repeat (30) @(posedge clk_i);
        chk(ptp, 1'h1, "shutdown pulse held");
        fail12 <= 1'h0;
        wfor(0, 1'h0, 40);
        chk(pulses, 2, "no second pulse on return");
        $display("test rail12_loss done");
        wb(1'h1, 8'h00, 32'h5, 32'h0, "");
        wb(1'h0, 8'h04, 32'h21, 32'h21, "status after preset");
        thermal_closed_i <= 1'h0;
        wfor(2, 1'h1, 10);
        wfor(4, 1'h0, 10);
        wfor(0, 1'h1, 15);
        wfor(0, 1'h0, 30);
        card_set <= 1'h1;
        @(posedge clk_i);
        chk(pnq | memory_normal_qualifier_o | core_read_o, 1'h0, "core off");
        chk(disc_wr | xy_drive_enable_o, 1'h0, "destructive off");
        card_set <= 1'h0;
        p12_dly <= 8'h1e + 8'($urandom() % 10);
        thermal_closed_i <= 1'h1;
        wfor(0, 1'h1, 20);
        wfor(3, 1'h1, 60);
        chk(ptp, 1'h1, "pulse waits for +12");
        wfor(0, 1'h0, 6);
        wfor(1, 1'h1, 60);
        chk({run1_o, run2_o, pulses[3:0]}, 6'h04, "restart halted");
        $display("test thermal done");
        power_sw <= 1'h0;
        wfor(0, 1'h1, 15);
        wfor(0, 1'h0, 30);
        wb(1'h0, 8'h08, 32'h5, 32'hffff, "pulse count");
        $display("test power_off done");
        conclude();
    end
endmodule
